// ### design/lsc_consts.vh
// Constants shared by the light sensor conversion control block.
`ifndef LSC_CONSTS_VH
`define LSC_CONSTS_VH
`define LSC_ADDR_CMD1       8'h00
`define LSC_ADDR_CMD2       8'h04
`define LSC_ADDR_DATA       8'h08
`define LSC_ADDR_THLO       8'h0C
`define LSC_ADDR_THHI       8'h10
`define LSC_ADDR_IRQ_STAT   8'h14
`define LSC_ADDR_IRQ_MASK   8'h18
`define LSC_ADDR_EXT        8'h1C
`define LSC_MODE_OFF        3'h0
`define LSC_MODE_VIS        3'h5
`define LSC_MODE_IR         3'h6
`define LSC_THHI_RESET      16'hFFFF
`define LSC_RESP_OKAY       2'h0
`define LSC_RESP_SLVERR     2'h2
`define LSC_EV_DONE         0
`define LSC_EV_ALARM        1
`endif

// ### design/lsc_persist.v
// Persistence filter counting consecutive out-of-window conversions.
`timescale 1ns/1ps
module lsc_persist
(
    // Clock and reset.
    input  wire        i_clock,
    input  wire        i_rst,
    // One pulse per finished conversion with its window result.
    input  wire        i_done,
    input  wire        i_outside,
    input  wire [1:0]  i_code,
    output reg         o_fire
);
    reg  [4:0] run;
    reg  [4:0] need;
    wire [4:0] next_run;
    always @*
    begin
        case (i_code)
            2'h0:    need = 5'h01;
            2'h1:    need = 5'h04;
            2'h2:    need = 5'h08;
            default: need = 5'h10;
        endcase
    end
    assign next_run = (run == 5'h1F) ? run : run + 5'h01;
    always @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            run    <= 5'h00;
            o_fire <= 1'b0;
        end
        else
        begin
            o_fire <= 1'b0;
            if (i_done)
            begin
                run    <= i_outside ? next_run : 5'h00;
                o_fire <= i_outside && (next_run >= need);
            end
        end
    end
endmodule

// ### design/lsc_sync2.v
// Two-stage synchroniser for a level from outside the clock domain.
`timescale 1ns/1ps
module lsc_sync2
(
    // Clock and reset.
    input  wire i_clock,
    input  wire i_rst,
    // Level in and out.
    input  wire i_async,
    output reg  o_sync
);
    reg stage1;
    always @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            stage1 <= 1'b0;
            o_sync <= 1'b0;
        end
        else
        begin
            stage1 <= i_async;
            o_sync <= stage1;
        end
    end
endmodule

// ### design/lsc_top.v
// Conversion sequencing, alarm and AXI4-Lite register file of the light sensor.
// Functional notes
// R1: After reset the block is powered down and the result reads zero.
// R2: A single command converts once, powers down, and keeps the result.
// R3: Continuous mode converts back to back, overwriting the result each time.
// R4: A power-down command stops conversion and powers the block down.
// R5: Internal timing counts oscillator cycles with a counter of 4, 8, 12 or 16 bits.
// R6: External timing integrates between two successive external timing commands.
// R7: The result is an unsigned count as wide as the selected resolution; external timing keeps the full 16-bit count.
// R8: Visible and infrared continuous sensing modes, programmable one after another.
// R9: Host-programmable range field; range 1 is the finest. range_code is only stored and read back; it does not affect the count.
// R10: Alarm is active low open drain, pulled low outside the threshold window.
// R11: Conversions continue after the alarm is asserted.
// R12: Alarm fires only after a configurable number of out-of-window conversions.
// R13: Host reads the alarming count before the next conversion overwrites it.
// R14: Host steps the range up when counts exceed 30000 under infrared light.
// R15: Mode field 000 powers down, 101 visible, 110 infrared, others reserved.
// R16: Persistence codes 00 to 11 need 1, 4, 8 or 16 consecutive cycles.
// R17: Alarm and its flag clear when a first command register write completes.
// R18: Resolution codes give 65536, 4096, 256 or 16 cycles per conversion.
`timescale 1ns/1ps
`include "lsc_consts.vh"
module lsc_top
(
    // Clock and reset.
    input  wire        i_clock,
    input  wire        i_rst,
    // Oscillator pin and sampled photo-current level.
    input  wire        i_osc,
    input  wire        i_light,
    // AXI4-Lite write address and data.
    input  wire [7:0]  i_awaddr,
    input  wire        i_awvalid,
    output reg         o_awready,
    input  wire [31:0] i_wdata,
    input  wire [3:0]  i_wstrb,
    input  wire        i_wvalid,
    output reg         o_wready,
    // AXI4-Lite write response.
    output reg  [1:0]  o_bresp,
    output reg         o_bvalid,
    input  wire        i_bready,
    // AXI4-Lite read.
    input  wire [7:0]  i_araddr,
    input  wire        i_arvalid,
    output reg         o_arready,
    output reg  [31:0] o_rdata,
    output reg  [1:0]  o_rresp,
    output reg         o_rvalid,
    input  wire        i_rready,
    // Alarm pin, open drain, and interrupt.
    output reg         o_alarm_out,
    output reg         o_alarm_oe_n,
    output reg         o_irq
);
    localparam ST_IDLE = 3'b001;
    localparam ST_INT  = 3'b010;
    localparam ST_EXT  = 3'b100;

    reg  [2:0]  state;
    reg  [2:0]  mode;
    reg  [1:0]  persist_code;
    reg  [1:0]  res_code;
    reg  [1:0]  range_code;
    reg         single;
    reg         ext_timing;
    reg  [15:0] th_lo;
    reg  [15:0] th_hi;
    reg  [15:0] result;
    reg  [15:0] osc_count;
    reg  [15:0] light_count;
    reg  [1:0]  irq_stat;
    reg  [1:0]  irq_mask;
    reg         alarm_flag;
    reg         done;
    reg  [15:0] done_value;
    reg         osc_prev;
    reg  [7:0]  aw_addr;
    reg         aw_held;
    reg  [31:0] w_data;
    reg         w_held;
    reg         w_strb0;
    reg         parked;
    reg  [15:0] last_cnt;
    reg  [15:0] next_value;
    wire        osc_sync;
    wire        light_sync;
    wire        osc_tick;
    wire        fire;
    wire        wr_go;
    wire        wr_cmd1;
    wire        wr_cmd2;
    wire        wr_ext;
    wire        ext_mark;
    wire        wr_map;

    lsc_sync2 u_sync_osc
    (
        .i_clock (i_clock),
        .i_rst   (i_rst),
        .i_async (i_osc),
        .o_sync  (osc_sync)
    );
    lsc_sync2 u_sync_light
    (
        .i_clock (i_clock),
        .i_rst   (i_rst),
        .i_async (i_light),
        .o_sync  (light_sync)
    );

    // Rising edges of the synchronised oscillator give the conversion enable.
    assign osc_tick = osc_sync && !osc_prev;

    // R18: cycles per resolution
    always @*
    begin
        case (res_code)
            2'h0:    last_cnt = 16'hFFFF;
            2'h1:    last_cnt = 16'h0FFF;
            2'h2:    last_cnt = 16'h00FF;
            default: last_cnt = 16'h000F;
        endcase
    end

    // R7: width-limited count
    always @*
    begin
        next_value = light_count & last_cnt;
        if (ext_timing)
        begin
            next_value = light_count;
        end
    end

    // Write channel capture; address and data may arrive in either order.
    assign wr_go   = aw_held && w_held && !o_bvalid;
    assign wr_cmd1 = wr_go && aw_addr == `LSC_ADDR_CMD1;
    assign wr_cmd2 = wr_go && aw_addr == `LSC_ADDR_CMD2;
    assign wr_ext  = wr_go && aw_addr == `LSC_ADDR_EXT;
    assign ext_mark = wr_ext && w_data[0];
    assign wr_map  = aw_addr == `LSC_ADDR_CMD1 || aw_addr == `LSC_ADDR_CMD2 ||
                     aw_addr == `LSC_ADDR_THLO || aw_addr == `LSC_ADDR_THHI ||
                     aw_addr == `LSC_ADDR_IRQ_STAT || aw_addr == `LSC_ADDR_IRQ_MASK ||
                     aw_addr == `LSC_ADDR_EXT || aw_addr == `LSC_ADDR_DATA;

    always @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_awready <= 1'b1;
            o_wready  <= 1'b1;
            aw_held   <= 1'b0;
            w_held    <= 1'b0;
            aw_addr   <= 8'h00;
            w_data    <= 32'h00000000;
            w_strb0   <= 1'b0;
            o_bvalid  <= 1'b0;
            o_bresp   <= `LSC_RESP_OKAY;
        end
        else
        begin
            if (i_awvalid && o_awready)
            begin
                aw_addr   <= i_awaddr;
                aw_held   <= 1'b1;
                o_awready <= 1'b0;
            end
            if (i_wvalid && o_wready)
            begin
                w_data   <= i_wdata;
                w_strb0  <= i_wstrb[0];
                w_held   <= 1'b1;
                o_wready <= 1'b0;
            end
            if (wr_go)
            begin
                o_bvalid <= 1'b1;
                o_bresp  <= wr_map ? `LSC_RESP_OKAY : `LSC_RESP_SLVERR;
                aw_held  <= 1'b0;
                w_held   <= 1'b0;
            end
            if (o_bvalid && i_bready)
            begin
                o_bvalid  <= 1'b0;
                o_awready <= 1'b1;
                o_wready  <= 1'b1;
            end
        end
    end

    // Configuration registers.
    always @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            mode         <= `LSC_MODE_OFF;
            persist_code <= 2'h0;
            res_code     <= 2'h0;
            range_code   <= 2'h0;
            single       <= 1'b0;
            ext_timing   <= 1'b0;
            th_lo        <= 16'h0000;
            th_hi        <= `LSC_THHI_RESET;
            irq_mask     <= 2'h0;
        end
        else if (wr_go)
        begin
            if (wr_cmd1 && w_strb0)
            begin
                // R15: mode field
                mode         <= w_data[7:5];
                persist_code <= w_data[1:0];
                single       <= w_data[8];
            end
            if (wr_cmd2 && w_strb0)
            begin
                // R9: range selection
                range_code <= w_data[1:0];
                res_code   <= w_data[3:2];
                ext_timing <= w_data[4];
            end
            if (aw_addr == `LSC_ADDR_THLO)
            begin
                th_lo <= w_data[15:0];
            end
            if (aw_addr == `LSC_ADDR_THHI)
            begin
                th_hi <= w_data[15:0];
            end
            if (aw_addr == `LSC_ADDR_IRQ_MASK)
            begin
                irq_mask <= w_data[1:0];
            end
        end
    end

    // Conversion sequencer.
    always @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            state       <= ST_IDLE;
            osc_prev    <= 1'b0;
            osc_count   <= 16'h0000;
            light_count <= 16'h0000;
            done        <= 1'b0;
            done_value  <= 16'h0000;
            parked      <= 1'b0;
        end
        else
        begin
            osc_prev <= osc_sync;
            done     <= 1'b0;
            // R2: rewrite re-arms
            if (wr_cmd1)
            begin
                parked <= 1'b0;
            end
            case (state)
                ST_IDLE:
                begin
                    osc_count   <= 16'h0000;
                    light_count <= 16'h0000;
                    // R8: visible or infrared
                    if (!parked && (mode == `LSC_MODE_VIS || mode == `LSC_MODE_IR))
                    begin
                        // R6: wait for first mark
                        if (ext_timing)
                        begin
                            if (ext_mark)
                            begin
                                state <= ST_EXT;
                            end
                        end
                        else
                        begin
                            state <= ST_INT;
                        end
                    end
                end
                ST_INT:
                begin
                    // R4: power-down stops conversion
                    if (mode != `LSC_MODE_VIS && mode != `LSC_MODE_IR)
                    begin
                        state <= ST_IDLE;
                    end
                    else if (osc_tick)
                    begin
                        // R5: n-bit oscillator count
                        if (osc_count == last_cnt)
                        begin
                            done        <= 1'b1;
                            done_value  <= next_value;
                            osc_count   <= 16'h0000;
                            light_count <= 16'h0000;
                            // R3: back to back
                            state <= single ? ST_IDLE : ST_INT;
                            // R2: single shot parks
                            parked <= single;
                        end
                        else
                        begin
                            osc_count <= osc_count + 16'h0001;
                            if (light_sync && light_count != 16'hFFFF)
                            begin
                                light_count <= light_count + 16'h0001;
                            end
                        end
                    end
                end
                ST_EXT:
                begin
                    if (mode != `LSC_MODE_VIS && mode != `LSC_MODE_IR)
                    begin
                        state <= ST_IDLE;
                    end
                    // R6: second mark ends integration
                    else if (ext_mark)
                    begin
                        done        <= 1'b1;
                        done_value  <= next_value;
                        light_count <= 16'h0000;
                        state       <= single ? ST_IDLE : ST_EXT;
                        parked      <= single;
                    end
                    else if (osc_tick && light_sync && light_count != 16'hFFFF)
                    begin
                        light_count <= light_count + 16'h0001;
                    end
                end
                default:
                begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // Single shot keeps the mode field readable, so a parked flag, not the mode, blocks a restart.

    lsc_persist u_persist
    (
        .i_clock   (i_clock),
        .i_rst     (i_rst),
        .i_done    (done),
        .i_outside (done_value > th_hi || done_value < th_lo),
        .i_code    (persist_code),
        .o_fire    (fire)
    );

    // Result, alarm flag and interrupt status.
    always @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            // R1: result starts at zero
            result       <= 16'h0000;
            alarm_flag   <= 1'b0;
            irq_stat     <= 2'h0;
            o_alarm_out  <= 1'b0;
            o_alarm_oe_n <= 1'b1;
            o_irq        <= 1'b0;
        end
        else
        begin
            // R11: result refresh ignores the alarm
            if (done)
            begin
                result <= done_value;
            end
            // R12: persistence gate
            // R16: persistence codes
            if (fire)
            begin
                alarm_flag <= 1'b1;
            end
            // R17: clear on command write
            else if (wr_cmd1)
            begin
                alarm_flag <= 1'b0;
            end
            // Set wins over a write-one clear in the same cycle.
            irq_stat[`LSC_EV_DONE]  <= done ||
                (irq_stat[`LSC_EV_DONE] && !(wr_go && aw_addr == `LSC_ADDR_IRQ_STAT && w_data[0]));
            irq_stat[`LSC_EV_ALARM] <= fire ||
                (irq_stat[`LSC_EV_ALARM] && !(wr_go && aw_addr == `LSC_ADDR_IRQ_STAT && w_data[1]));
            o_irq        <= |(irq_stat & irq_mask);
            // R10: active low open drain
            o_alarm_out  <= 1'b0;
            o_alarm_oe_n <= !alarm_flag;
        end
    end

    // Read channel; one read outstanding, answered one cycle after the address.
    always @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_arready <= 1'b1;
            o_rvalid  <= 1'b0;
            o_rdata   <= 32'h00000000;
            o_rresp   <= `LSC_RESP_OKAY;
        end
        else if (o_rvalid)
        begin
            if (i_rready)
            begin
                o_rvalid  <= 1'b0;
                o_arready <= 1'b1;
            end
        end
        else if (i_arvalid && o_arready)
        begin
            o_arready <= 1'b0;
            o_rvalid  <= 1'b1;
            o_rresp   <= `LSC_RESP_OKAY;
            case (i_araddr)
                `LSC_ADDR_CMD1:     o_rdata <= {23'h000000, single, mode, 2'h0, alarm_flag, persist_code};
                `LSC_ADDR_CMD2:     o_rdata <= {27'h0000000, ext_timing, res_code, range_code};
                `LSC_ADDR_DATA:     o_rdata <= {16'h0000, result};
                `LSC_ADDR_THLO:     o_rdata <= {16'h0000, th_lo};
                `LSC_ADDR_THHI:     o_rdata <= {16'h0000, th_hi};
                `LSC_ADDR_IRQ_STAT: o_rdata <= {30'h00000000, irq_stat};
                `LSC_ADDR_IRQ_MASK: o_rdata <= {30'h00000000, irq_mask};
                `LSC_ADDR_EXT:      o_rdata <= {29'h00000000, state};
                default:
                begin
                    o_rdata <= 32'h00000000;
                    o_rresp <= `LSC_RESP_SLVERR;
                end
            endcase
        end
    end
endmodule

// ### sim/lsc_checker.sv
// Concurrent checks on the ports of the light sensor block.
`timescale 1ns/1ps
`include "lsc_consts.vh"
module lsc_checker
(
    // Clock and reset.
    input wire        i_clock,
    input wire        i_rst,
    // Oscillator and light.
    input wire        i_osc,
    input wire        i_light,
    // Register bus.
    input wire [7:0]  i_awaddr,
    input wire        i_awvalid,
    input wire        o_awready,
    input wire [31:0] i_wdata,
    input wire [3:0]  i_wstrb,
    input wire        i_wvalid,
    input wire        o_wready,
    input wire [1:0]  o_bresp,
    input wire        o_bvalid,
    input wire        i_bready,
    input wire [7:0]  i_araddr,
    input wire        i_arvalid,
    input wire        o_arready,
    input wire [31:0] o_rdata,
    input wire [1:0]  o_rresp,
    input wire        o_rvalid,
    input wire        i_rready,
    // Alarm and interrupt.
    input wire        o_alarm_out,
    input wire        o_alarm_oe_n,
    input wire        o_irq
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_rst);
    AST_WR_ANSWER: assert property ((i_awvalid && o_awready && i_wvalid && o_wready) |-> ##2 o_bvalid)
        else $error("write response not two cycles after address and data");
    AST_RD_ANSWER: assert property ((i_arvalid && o_arready) |=> o_rvalid)
        else $error("read data not one cycle after address");
    AST_B_STANDS: assert property ((o_bvalid && !i_bready) |=> (o_bvalid && $stable(o_bresp)))
        else $error("write response dropped before taken");
    AST_R_STANDS: assert property ((o_rvalid && !i_rready) |=> (o_rvalid && $stable(o_rdata)))
        else $error("read data changed before taken");
    AST_W_REFUSED: assert property (o_bvalid |-> (!o_awready && !o_wready))
        else $error("write accepted while response pending");
    AST_PIN_VALUE: assert property (o_alarm_out == 1'b0)
        else $error("alarm pin drives a high level");
    AST_ERR_DATA: assert property ((o_rvalid && o_rresp == `LSC_RESP_SLVERR) |-> o_rdata == 32'h0)
        else $error("refused read returns data");
    AST_ALARM_CLEAR: assert property ((i_awvalid && o_awready && i_awaddr == `LSC_ADDR_CMD1 && i_wvalid
        && o_wready) |-> ##[1:3] o_alarm_oe_n)
        else $error("alarm not released by command write");
    cover property ($fell(o_alarm_oe_n));
    cover property (o_rvalid && o_rresp == `LSC_RESP_SLVERR);
    cover property ($rose(o_irq));
endmodule

// ### sim/lsc_light_src.sv
// Oscillator and photo level source facing the conversion block.
`timescale 1ns/1ps
module lsc_light_src
(
    // Pattern: 0 dark, 1 half, 2 bright.
    input  wire [1:0] i_level,
    // Oscillator and light.
    output logic      o_osc,
    output logic      o_light
);
    logic half;
    initial
    begin
        o_osc = 1'b0;
        o_light = 1'b0;
        half = 1'b0;
        forever #80 o_osc = ~o_osc;
    end
    // Light moves on falling edges so it never races a counting edge.
    always @(negedge o_osc)
    begin
        half <= ~half;
        o_light <= (i_level == 2'h2) || (i_level == 2'h1 && !half);
    end
endmodule

// ### sim/tb_top.sv
// Self-checking bench for the light sensor conversion block.
`timescale 1ns/1ps
`include "lsc_consts.vh"
module tb_top;
    logic        i_clock, i_rst, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
    logic [7:0]  i_awaddr, i_araddr;
    logic [31:0] i_wdata, r;
    logic [3:0]  i_wstrb;
    logic [1:0]  level, o_bresp, o_rresp;
    logic [31:0] o_rdata;
    logic [65:0] e;
    logic [65:0] rq[$];
    wire         i_osc, i_light, o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
    wire         o_alarm_out, o_alarm_oe_n, o_irq;
    int          error_cnt, n_checks, seed, c, k, n;
    time         t0, t_ev;
    lsc_top dut (.*);
    lsc_light_src src (.i_level(level), .o_osc(i_osc), .o_light(i_light));
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic report_and_stop;
        if (error_cnt == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] rs = `LSC_RESP_OKAY);
        @(posedge i_clock);
        i_awaddr <= a;
        i_wdata <= d;
        i_awvalid <= 1'b1;
        i_wvalid <= 1'b1;
        i_bready <= 1'b1;
        do
        begin
            @(posedge i_clock);
            if (o_awready)
                i_awvalid <= 1'b0;
            if (o_wready)
                i_wvalid <= 1'b0;
        end while (!o_bvalid);
        i_bready <= 1'b0;
        chk("bresp", {30'h0, o_bresp}, {30'h0, rs});
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m,
                      input logic [1:0] rs = `LSC_RESP_OKAY);
        @(posedge i_clock);
        i_araddr <= a;
        i_arvalid <= 1'b1;
        i_rready <= 1'b1;
        rq.push_back({rs, m, x});
        do
        begin
            @(posedge i_clock);
            if (o_arready)
                i_arvalid <= 1'b0;
        end while (!o_rvalid);
        i_rready <= 1'b0;
    endtask
    // Waits for a finished conversion and clears its status bit.
    task automatic nxt;
        do @(posedge i_clock); while (!o_irq);
        t_ev = $time;
        wr(`LSC_ADDR_IRQ_STAT, 32'h1);
        repeat (3) @(posedge i_clock);
    endtask
    always @(posedge i_clock)
        if (o_rvalid && i_rready && rq.size() > 0)
        begin
            e = rq.pop_front();
            chk("rdata", o_rdata & e[63:32], e[31:0]);
            chk("rresp", {30'h0, o_rresp}, {30'h0, e[65:64]});
        end
    initial
    begin
        i_clock = 1'b0;
        forever #4 i_clock = ~i_clock;
    end
    initial
    begin
        #400000;
        error_cnt++;
        report_and_stop();
    end
    initial
    begin
        {i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready, i_awaddr, i_araddr, i_wdata} = '0;
        i_wstrb = 4'hF;
        i_rst = 1'b1;
        level = 2'h0;
        seed = 63;
        repeat (8) @(posedge i_clock);
        i_rst <= 1'b0;
        rd(`LSC_ADDR_DATA, 32'h0, 32'hFFFFFFFF);
        rd(`LSC_ADDR_CMD1, 32'h0, 32'hFFFFFFFF);
        rd(`LSC_ADDR_THHI, 32'hFFFF, 32'hFFFFFFFF);
        rd(`LSC_ADDR_EXT, 32'h1, 32'h7);
        rd(8'h20, 32'h0, 32'hFFFFFFFF, `LSC_RESP_SLVERR);
        wr(8'h20, 32'h0, `LSC_RESP_SLVERR);
        repeat (3)
        begin
            r = $random(seed);
            wr(`LSC_ADDR_THLO, {16'h0, r[15:0]});
            rd(`LSC_ADDR_THLO, {16'h0, r[15:0]}, 32'hFFFFFFFF);
        end
        wr(`LSC_ADDR_IRQ_MASK, 32'h1);
        wr(`LSC_ADDR_CMD2, 32'hC);
        wr(`LSC_ADDR_THLO, 32'h4);
        wr(`LSC_ADDR_THHI, 32'hC);
        // Back to back conversions, 16 cycles each.
        level <= 2'h1;
        wr(`LSC_ADDR_CMD1, {24'h0, `LSC_MODE_VIS, 5'h0});
        nxt();
        nxt();
        t0 = t_ev;
        nxt();
        chk("period16", (t_ev - t0 >= 2400 && t_ev - t0 <= 2880), 1);
        rd(`LSC_ADDR_DATA, 32'h0, 32'hFFFFFFF0);
        chk("alarm_in", o_alarm_oe_n, 1);
        for (c = 0; c < 4; c++)
        begin
            n = (c == 0) ? 1 : 4 << (c - 1);
            level <= 2'h1;
            nxt();
            nxt();
            wr(`LSC_ADDR_CMD1, {24'h0, `LSC_MODE_VIS, 3'h0, c[1:0]});
            do @(posedge i_clock); while (!o_irq);
            level <= 2'h0;
            wr(`LSC_ADDR_IRQ_STAT, 32'h1);
            repeat (3) @(posedge i_clock);
            for (k = 1; k <= n + 1; k++)
            begin
                nxt();
                chk("alarm_n", o_alarm_oe_n, k < n);
            end
            rd(`LSC_ADDR_CMD1, 32'h4, 32'h4);
            wr(`LSC_ADDR_CMD1, {24'h0, `LSC_MODE_VIS, 3'h0, c[1:0]});
            @(posedge i_clock);
            chk("alarm_clr", o_alarm_oe_n, 1);
            rd(`LSC_ADDR_CMD1, 32'h0, 32'h4);
        end
        // Infrared mode keeps converting.
        wr(`LSC_ADDR_CMD1, {24'h0, `LSC_MODE_IR, 5'h0});
        nxt();
        rd(`LSC_ADDR_EXT, 32'h2, 32'h7);
        wr(`LSC_ADDR_CMD1, 32'h0);
        wr(`LSC_ADDR_IRQ_STAT, 32'h3);
        rd(`LSC_ADDR_EXT, 32'h1, 32'h7);
        repeat (400) @(posedge i_clock);
        chk("irq_off", o_irq, 0);
        // Single shot at 256 cycles.
        level <= 2'h2;
        wr(`LSC_ADDR_CMD2, 32'h9);
        rd(`LSC_ADDR_CMD2, 32'h9, 32'h1F);
        t0 = $time;
        wr(`LSC_ADDR_CMD1, {23'h0, 1'b1, `LSC_MODE_VIS, 5'h0});
        rd(`LSC_ADDR_EXT, 32'h2, 32'h7);
        nxt();
        chk("period256", (t_ev - t0 >= 40640 && t_ev - t0 <= 41280), 1);
        repeat (400) @(posedge i_clock);
        rd(`LSC_ADDR_EXT, 32'h1, 32'h7);
        rd(`LSC_ADDR_DATA, 32'hFF, 32'hFFFFFFFF);
        chk("irq_once", o_irq, 0);
        // External timing between two marks.
        level <= 2'h0;
        wr(`LSC_ADDR_CMD2, 32'h1C);
        wr(`LSC_ADDR_CMD1, {24'h0, `LSC_MODE_VIS, 5'h0});
        wr(`LSC_ADDR_EXT, 32'h1);
        rd(`LSC_ADDR_EXT, 32'h4, 32'h7);
        repeat (300) @(posedge i_clock);
        wr(`LSC_ADDR_EXT, 32'h1);
        do @(posedge i_clock); while (!o_irq);
        wr(`LSC_ADDR_IRQ_MASK, 32'h0);
        @(posedge i_clock);
        chk("irq_mask", o_irq, 0);
        wr(`LSC_ADDR_IRQ_MASK, 32'h1);
        @(posedge i_clock);
        chk("irq_unmask", o_irq, 1);
        rd(`LSC_ADDR_DATA, 32'h0, 32'hFFFFFFFF);
        wr(`LSC_ADDR_IRQ_STAT, 32'h1);
        repeat (2) @(posedge i_clock);
        chk("irq_clr", o_irq, 0);
        report_and_stop();
    end
endmodule
bind lsc_top lsc_checker chk (.*);
